// [bench/debug_host_model.sv]
// Debug host on the serial front end: one command per call.
// Assumes the caller enters send at a falling edge.
`timescale 1ns/1ps
module debug_host_model
   import mode_ctrl_pkg::*;
(
   // Clock and mode seen by the host
   input wire logic clk_i,
   input wire mode_type mode_i,
   // Request to the block
   output debug_req_type debug_req_o
);
   initial debug_req_o = '0;
   // Active-only commands are dropped outside background mode unless misuse is asked
   task automatic send(input debug_cmd_type cmd, input bit misuse);
      if (misuse || cmd < CMD_CPU_REG || mode_i == MODE_HALT_TO_DEBUG_INSTRUCTION) begin
         debug_req_o = {1'b1, cmd};
         @(negedge clk_i);
         debug_req_o = '0;
      end
   endtask
endmodule

// [bench/operating_mode_control_props.sv]
// Checker for the mode sequencer, bound to its top module.
// Assumes the single clk_i domain with synchronous active-high rst_i.
`timescale 1ns/1ps
module operating_mode_control_props
   import mode_ctrl_pkg::*;
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Watched inputs
   input wire logic secured_i,
   input wire logic vec_ready_i,
   input wire logic irq_req_i,
   input wire debug_req_type debug_req_i,
   input wire logic [PERIPH_COUNT-1:0] peripheral_clock_gate_regs_i,
   // Watched outputs
   input wire logic [15:0] fetch_addr_o,
   input wire logic start_pc_valid_o,
   input wire logic cpu_run_o,
   input wire logic cpu_clk_en_o,
   input wire logic irq_stack_o,
   input wire logic halt_to_debug_instruction_entry_o,
   input wire mode_type mode_o,
   input wire debug_resp_type debug_resp_o,
   input wire logic [PERIPH_COUNT-1:0] periph_clk_en_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   sequence s_lo_byte;
      mode_o == MODE_VEC_LO && vec_ready_i;
   endsequence
   sequence s_wait_status;
      mode_o == MODE_WAIT && debug_req_i.valid && debug_req_i.cmd == CMD_MEM_STATUS;
   endsequence
   a_vec_hi_fetch: assert property (
      mode_o == MODE_VEC_HI |-> fetch_addr_o == RESET_VECTOR_ADDR)
      else $error("vector high fetch address wrong");
   a_start_pc_valid: assert property (
      s_lo_byte |=> start_pc_valid_o) else $error("start address not given");
   a_halt_to_debug_instruction_cpu_held: assert property (
      mode_o == MODE_HALT_TO_DEBUG_INSTRUCTION |-> !cpu_run_o) else $error("cpu runs in background");
   a_wait_clk_off: assert property (
      mode_o == MODE_WAIT |-> !cpu_clk_en_o) else $error("cpu clock on in wait");
   a_wait_low_power: assert property (
      s_wait_status |=> debug_resp_o == {1'b1, 1'b0, STATUS_LOW_POWER})
      else $error("wait status answer wrong");
   a_run_refused: assert property (
      mode_o == MODE_RUN && debug_req_i.valid && debug_req_i.cmd >= CMD_CPU_REG
      |=> debug_resp_o.status == STATUS_REFUSED) else $error("active command not refused");
   a_irq_wake: assert property (
      mode_o == MODE_WAIT && irq_req_i && !debug_req_i.valid
      |=> mode_o == MODE_RUN && irq_stack_o) else $error("interrupt did not wake");
   a_secure_block: assert property (
      secured_i && mode_o == MODE_RUN && !debug_req_i.valid |=> !halt_to_debug_instruction_entry_o)
      else $error("entry while secured");
   a_entry_single: assert property (
      halt_to_debug_instruction_entry_o |-> mode_o == MODE_HALT_TO_DEBUG_INSTRUCTION ##1 !halt_to_debug_instruction_entry_o) else $error("entry repeated");
   a_periph_follow: assert property (
      !$past(rst_i) |-> periph_clk_en_o == $past(peripheral_clock_gate_regs_i))
      else $error("peripheral clock mismatch");
endmodule

bind operating_mode_control operating_mode_control_props i_props (.clk_i, .rst_i, .secured_i,
   .vec_ready_i, .irq_req_i, .debug_req_i, .peripheral_clock_gate_regs_i, .fetch_addr_o,
   .start_pc_valid_o, .cpu_run_o, .cpu_clk_en_o, .irq_stack_o, .halt_to_debug_instruction_entry_o, .mode_o,
   .debug_resp_o, .periph_clk_en_o);

// [bench/tb_top.sv]
// Self-checking bench for the operating-mode sequencer.
// Assumes a 100 MHz clock; inputs change at the falling edge.
`timescale 1ns/1ps
module tb_top;
   import mode_ctrl_pkg::*;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic por_i = 1'b1;
   logic force_reset_i = 1'b0;
   logic debug_mode_select_pin_i = 1'b1;
   logic secured_i = 1'b0;
   logic irq_req_i = 1'b0;
   logic vec_ready_i = 1'b0;
   logic [7:0] vec_data_i = 8'h00;
   logic [PERIPH_COUNT-1:0] peripheral_clock_gate_regs_i = 16'hFFFF;
   cpu_event_type cpu_event_i = '0;
   debug_req_type debug_req_i;
   logic [15:0] fetch_addr_o, start_pc_o;
   logic vec_read_o, start_pc_valid_o, cpu_run_o, clear_imask_o, irq_stack_o, halt_to_debug_instruction_entry_o;
   logic cpu_clk_en_o, sys_clk_en_o, regulator_full_o;
   logic [PERIPH_COUNT-1:0] periph_clk_en_o;
   mode_type mode_o;
   debug_resp_type debug_resp_o;
   int error_cnt = 0;
   int tests_run = 0;
   int cycles = 0;
   operating_mode_control i_dut (.clk_i, .rst_i, .por_i, .force_reset_i,
      .debug_mode_select_pin_i, .secured_i, .cpu_event_i, .irq_req_i, .vec_ready_i,
      .vec_data_i, .peripheral_clock_gate_regs_i, .debug_req_i, .fetch_addr_o, .vec_read_o,
      .start_pc_o, .start_pc_valid_o, .cpu_run_o, .clear_imask_o, .irq_stack_o,
      .halt_to_debug_instruction_entry_o, .mode_o, .debug_resp_o, .cpu_clk_en_o, .periph_clk_en_o,
      .sys_clk_en_o, .regulator_full_o);
   debug_host_model i_host (.clk_i, .mode_i(mode_o), .debug_req_o(debug_req_i));
   initial forever #5 clk_i = ~clk_i;
   // Whole run is well under a thousand cycles
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 3000) begin
         error_cnt++;
         summarize();
      end
   end
   task automatic summarize();
      $display("Checks %0d, errors %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp) begin
         error_cnt++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge clk_i);
   endtask
   // Mode changes are waited for a few cycles, not assumed to the edge
   task automatic to_mode(input mode_type m);
      for (int i = 0; i < 8 && mode_o !== m; i++) cyc(1);
      chk("mode", 16'(mode_o), 16'(m));
   endtask
   task automatic pulse(input logic [4:0] e);
      cpu_event_i = cpu_event_type'(e);
      cyc(1);
      cpu_event_i = '0;
   endtask
   task automatic cmd(input debug_cmd_type c, input logic [3:0] exp);
      i_host.send(c, 1'b1);
      chk("resp", 16'(debug_resp_o), 16'(exp));
   endtask
   task automatic t_boot(input logic pin, input logic p, input logic f, input mode_type m);
      rst_i = 1'b1;
      debug_mode_select_pin_i = pin;
      por_i = p;
      force_reset_i = f;
      cyc(10);
      rst_i = 1'b0;
      to_mode(MODE_VEC_HI);
      chk("fetch", fetch_addr_o, RESET_VECTOR_ADDR);
      chk("vread", 16'(vec_read_o), 16'h0001);
      vec_ready_i = 1'b1;
      vec_data_i = 8'h12;
      cyc(1);
      vec_ready_i = 1'b0;
      to_mode(MODE_VEC_LO);
      chk("fetch", fetch_addr_o, RESET_VECTOR_ADDR_LO);
      vec_ready_i = 1'b1;
      vec_data_i = 8'h34;
      cyc(1);
      vec_ready_i = 1'b0;
      chk("pc", start_pc_o, 16'h1234);
      chk("pcvalid", 16'(start_pc_valid_o), 16'h0001);
      to_mode(m);
      debug_mode_select_pin_i = 1'b1;
   endtask
   task automatic t_cmds();
      for (int c = 0; c < 8; c++)
         if (c != 3) cmd(debug_cmd_type'(c), c < 4 ? 4'hC : 4'hA);
      cmd(CMD_BACKGROUND, 4'hC);
      chk("entry", 16'(halt_to_debug_instruction_entry_o), 16'h0001);
      to_mode(MODE_HALT_TO_DEBUG_INSTRUCTION);
      for (int c = 0; c < 8; c++)
         if (c != 3 && c != 5 && c != 6) cmd(debug_cmd_type'(c), 4'hC);
      cmd(CMD_TRACE, 4'hC);
      to_mode(MODE_TRACE);
      pulse(5'h04);
      to_mode(MODE_HALT_TO_DEBUG_INSTRUCTION);
      chk("entry", 16'(halt_to_debug_instruction_entry_o), 16'h0000);
      cmd(CMD_GO, 4'hC);
      to_mode(MODE_RUN);
      chk("run", 16'(cpu_run_o), 16'h0001);
   endtask
   task automatic t_entries();
      logic [4:0] evs [4] = '{5'h10, 5'h02, 5'h01, 5'h13};
      for (int i = 0; i < 4; i++) begin
         pulse(evs[i]);
         to_mode(MODE_HALT_TO_DEBUG_INSTRUCTION);
         cmd(CMD_GO, 4'hC);
         to_mode(MODE_RUN);
      end
      secured_i = 1'b1;
      pulse(5'h13);
      cyc(1);
      chk("mode", 16'(mode_o), 16'(MODE_RUN));
      secured_i = 1'b0;
   endtask
   task automatic t_wait();
      peripheral_clock_gate_regs_i = 16'hA5C3;
      pulse(5'h08);
      chk("imask", 16'(clear_imask_o), 16'h0001);
      to_mode(MODE_WAIT);
      chk("cpuclk", 16'(cpu_clk_en_o), 16'h0000);
      chk("sys", 16'({sys_clk_en_o, regulator_full_o}), 16'h0003);
      chk("periph", periph_clk_en_o, 16'hA5C3);
      cmd(CMD_MEM_STATUS, 4'h9);
      cmd(CMD_MEM_ACCESS, 4'hA);
      irq_req_i = 1'b1;
      cyc(1);
      irq_req_i = 1'b0;
      chk("stack", 16'(irq_stack_o), 16'h0001);
      to_mode(MODE_RUN);
      pulse(5'h08);
      to_mode(MODE_WAIT);
      cmd(CMD_BACKGROUND, 4'hC);
      to_mode(MODE_HALT_TO_DEBUG_INSTRUCTION);
   endtask
   initial begin
      t_boot(1'b0, 1'b1, 1'b0, MODE_HALT_TO_DEBUG_INSTRUCTION);
      t_boot(1'b0, 1'b0, 1'b1, MODE_HALT_TO_DEBUG_INSTRUCTION);
      t_boot(1'b1, 1'b1, 1'b0, MODE_RUN);
      t_cmds();
      t_entries();
      t_wait();
      summarize();
   end
endmodule

// [logic/mode_clock_gate.sv]
// Clock-enable generation for the CPU and the peripherals.
// Assumes the enables feed glitch-free gate cells outside this block.
`timescale 1ns/1ps
module mode_clock_gate
   import mode_ctrl_pkg::*;
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Controls
   input wire logic cpu_run_i,
   input wire logic [PERIPH_COUNT-1:0] gate_regs_i,
   // Enables
   output logic cpu_clk_en_o,
   output logic [PERIPH_COUNT-1:0] periph_clk_en_o,
   output logic sys_clk_en_o,
   output logic regulator_full_o
);

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cpu_clk_en_o <= 1'b0;
      end else begin
         cpu_clk_en_o <= cpu_run_i;
      end
   end

   // Bus clock and regulator never drop here; stop modes live elsewhere
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sys_clk_en_o <= 1'b1;
         regulator_full_o <= 1'b1;
      end else begin
         sys_clk_en_o <= 1'b1;
         regulator_full_o <= 1'b1;
      end
   end

   genvar g;
   generate
      for (g = 0; g < PERIPH_COUNT; g++) begin : gen_periph
         always_ff @(posedge clk_i) begin
            if (rst_i) begin
               periph_clk_en_o[g] <= 1'b1;
            end else begin
               periph_clk_en_o[g] <= gate_regs_i[g];
            end
         end
      end
   endgenerate

endmodule

// [logic/mode_ctrl_pkg.sv]
// Package for the operating-mode controller: modes, debug command classes,
// carrier structs and address, count and status constants.
// Assumes one 100 MHz clock domain and a synchronous active-high reset.
package mode_ctrl_pkg;

   localparam logic [15:0] RESET_VECTOR_ADDR = 16'hFFFE;
   localparam logic [15:0] RESET_VECTOR_ADDR_LO = 16'hFFFF;
   localparam int PERIPH_COUNT = 16;
   localparam logic [1:0] STATUS_OK = 2'h0;
   localparam logic [1:0] STATUS_LOW_POWER = 2'h1;
   localparam logic [1:0] STATUS_REFUSED = 2'h2;
   localparam logic ILLEGAL_OP_SEL = 1'b0;

   typedef enum logic [2:0] {
      MODE_RESET = 3'b000,
      MODE_VEC_HI = 3'b001,
      MODE_VEC_LO = 3'b010,
      MODE_RUN = 3'b011,
      MODE_HALT_TO_DEBUG_INSTRUCTION = 3'b100,
      MODE_TRACE = 3'b101,
      MODE_WAIT = 3'b110
   } mode_type;

   typedef enum logic [3:0] {
      CMD_MEM_ACCESS = 4'h0,
      CMD_MEM_STATUS = 4'h1,
      CMD_DBGREG_ACCESS = 4'h2,
      CMD_BACKGROUND = 4'h3,
      CMD_CPU_REG = 4'h4,
      CMD_TRACE = 4'h5,
      CMD_GO = 4'h6,
      CMD_OTHER_ACTIVE = 4'h7
   } debug_cmd_type;

   // One command from the serial debug front end
   typedef struct packed {
      logic valid;
      debug_cmd_type cmd;
   } debug_req_type;

   // Answer to the debug front end
   typedef struct packed {
      logic valid;
      logic execute;
      logic [1:0] status;
   } debug_resp_type;

   // Events reported by the CPU core
   typedef struct packed {
      logic halt_instr;
      logic wait_instr;
      logic instr_done;
      logic bdc_break;
      logic dbg_break;
   } cpu_event_type;

endpackage

// [logic/operating_mode_control.sv]
// Operating-mode sequencer: reset vector fetch, run, background and wait.
// Assumes the CPU, the debug serial front end and the interrupt logic sit
// outside; all inputs are synchronous to clk_i.
`timescale 1ns/1ps

// Behaviour
// - After reset fetch the vector at 0xFFFE-0xFFFF and start there.
// - Debug select pin low at power-on reset enters background mode.
// - Debug select pin low after forced debug reset enters background mode.
// - BACKGROUND serial command enters background mode.
// - Halt-to-debug instruction enters background mode.
// - Debug controller or debug module breakpoint enters background mode.
// - Command, instruction and breakpoint entries need an unsecured device.
// - In background mode the CPU is suspended awaiting commands.
// - Non-intrusive commands are accepted in run and background modes.
// - CPU register, trace and GO commands execute only in background mode.
// - Trace runs exactly one instruction then suspends again.
// - GO leaves background mode and resumes the user program.
// - Wait instruction stops the CPU clock.
// - Entering wait clears the interrupt mask bit.
// - An interrupt in wait restarts the CPU into interrupt stacking unless an unsecured BACKGROUND command comes in the same cycle.
// - In wait, system clocks and full regulation stay on.
// - In wait only BACKGROUND and memory-with-status commands are accepted.
// - Memory-with-status in wait returns low-power error without access.
// - BACKGROUND in wait wakes into background mode.
// - In wait, peripheral clocks follow their gate registers.
module operating_mode_control
   import mode_ctrl_pkg::*;
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Reset cause
   input wire logic por_i,
   input wire logic force_reset_i,
   // Pin and security
   input wire logic debug_mode_select_pin_i,
   input wire logic secured_i,
   // CPU side
   input wire cpu_event_type cpu_event_i,
   input wire logic irq_req_i,
   input wire logic vec_ready_i,
   input wire logic [7:0] vec_data_i,
   input wire logic [PERIPH_COUNT-1:0] peripheral_clock_gate_regs_i,
   // Debug front end
   input wire debug_req_type debug_req_i,
   // CPU control
   output logic [15:0] fetch_addr_o,
   output logic vec_read_o,
   output logic [15:0] start_pc_o,
   output logic start_pc_valid_o,
   output logic cpu_run_o,
   output logic clear_imask_o,
   output logic irq_stack_o,
   output logic halt_to_debug_instruction_entry_o,
   output mode_type mode_o,
   // Debug answer
   output debug_resp_type debug_resp_o,
   // Clocks
   output logic cpu_clk_en_o,
   output logic [PERIPH_COUNT-1:0] periph_clk_en_o,
   output logic sys_clk_en_o,
   output logic regulator_full_o
);

   mode_type mode_reg;
   mode_type mode_next;
   logic [15:0] vec_reg;
   logic boot_halt_to_debug_instruction_reg;
   debug_resp_type resp_next;
   logic enter_halt_to_debug_instruction;
   logic cmd_halt_to_debug_instruction;
   logic gated_entry;
   logic cpu_run_next;
   logic [15:0] vec_hi_word;
   logic [15:0] vec_lo_word;

   assign vec_hi_word = {vec_data_i, 8'h00};
   assign vec_lo_word = {vec_reg[15:8], vec_data_i};

   // The pin is sampled in the first cycle after release, never under reset
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         boot_halt_to_debug_instruction_reg <= 1'b0;
      end else if (mode_reg == MODE_RESET) begin
         // Pin paths bypass security
         boot_halt_to_debug_instruction_reg <= !debug_mode_select_pin_i && (por_i || force_reset_i);
      end
   end

   // Entry paths that require an unsecured device
   always_comb begin
      cmd_halt_to_debug_instruction = debug_req_i.valid && (debug_req_i.cmd == CMD_BACKGROUND);
      gated_entry = cmd_halt_to_debug_instruction || cpu_event_i.halt_instr
         || cpu_event_i.bdc_break || cpu_event_i.dbg_break;
      // OR of all sources: one entry however many coincide
      enter_halt_to_debug_instruction = gated_entry && !secured_i;
   end

   always_comb begin
      mode_next = mode_reg;
      case (mode_reg)
         MODE_RESET: begin
            mode_next = MODE_VEC_HI;
         end
         MODE_VEC_HI: begin
            if (vec_ready_i) begin
               mode_next = MODE_VEC_LO;
            end
         end
         MODE_VEC_LO: begin
            if (vec_ready_i) begin
               mode_next = boot_halt_to_debug_instruction_reg ? MODE_HALT_TO_DEBUG_INSTRUCTION : MODE_RUN;
            end
         end
         MODE_RUN: begin
            if (enter_halt_to_debug_instruction) begin
               mode_next = MODE_HALT_TO_DEBUG_INSTRUCTION;
            end else if (cpu_event_i.wait_instr) begin
               mode_next = MODE_WAIT;
            end
         end
         MODE_HALT_TO_DEBUG_INSTRUCTION: begin
            if (debug_req_i.valid && debug_req_i.cmd == CMD_TRACE) begin
               mode_next = MODE_TRACE;
            end else if (debug_req_i.valid && debug_req_i.cmd == CMD_GO) begin
               mode_next = MODE_RUN;
            end
         end
         MODE_TRACE: begin
            if (cpu_event_i.instr_done) begin
               mode_next = MODE_HALT_TO_DEBUG_INSTRUCTION;
            end
         end
         MODE_WAIT: begin
            if (cmd_halt_to_debug_instruction && !secured_i) begin
               mode_next = MODE_HALT_TO_DEBUG_INSTRUCTION;
            end else if (irq_req_i) begin
               mode_next = MODE_RUN;
            end
         end
         default: begin
            mode_next = MODE_RESET;
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mode_reg <= MODE_RESET;
      end else begin
         mode_reg <= mode_next;
      end
   end

   // Vector fetch address, high byte first
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         fetch_addr_o <= RESET_VECTOR_ADDR;
      end else if (mode_next == MODE_VEC_LO) begin
         fetch_addr_o <= RESET_VECTOR_ADDR_LO;
      end else begin
         fetch_addr_o <= RESET_VECTOR_ADDR;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         vec_read_o <= 1'b0;
      end else begin
         vec_read_o <= (mode_next == MODE_VEC_HI) || (mode_next == MODE_VEC_LO);
      end
   end

   // Assembly register holds the high byte until the low byte arrives
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         vec_reg <= 16'h0000;
      end else if (mode_reg == MODE_VEC_HI && vec_ready_i) begin
         vec_reg <= vec_hi_word;
      end else if (mode_reg == MODE_VEC_LO && vec_ready_i) begin
         vec_reg <= vec_lo_word;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         start_pc_o <= 16'h0000;
      end else if (mode_reg == MODE_VEC_LO && vec_ready_i) begin
         start_pc_o <= vec_lo_word;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         start_pc_valid_o <= 1'b0;
      end else begin
         start_pc_valid_o <= (mode_reg == MODE_VEC_LO) && vec_ready_i;
      end
   end

   // CPU runs in run mode and for the one traced instruction only
   always_comb begin
      cpu_run_next = (mode_next == MODE_RUN) || (mode_next == MODE_TRACE);
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cpu_run_o <= 1'b0;
      end else begin
         cpu_run_o <= cpu_run_next;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mode_o <= MODE_RESET;
      end else begin
         mode_o <= mode_next;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         clear_imask_o <= 1'b0;
      end else begin
         clear_imask_o <= (mode_reg == MODE_RUN) && (mode_next == MODE_WAIT);
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_stack_o <= 1'b0;
      end else begin
         irq_stack_o <= (mode_reg == MODE_WAIT) && (mode_next == MODE_RUN);
      end
   end

   // Single pulse per entry, even with coincident causes
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         halt_to_debug_instruction_entry_o <= 1'b0;
      end else begin
         halt_to_debug_instruction_entry_o <= (mode_next == MODE_HALT_TO_DEBUG_INSTRUCTION) && (mode_reg != MODE_HALT_TO_DEBUG_INSTRUCTION)
            && (mode_reg != MODE_TRACE);
      end
   end

   // Commands that may run beside the user program
   function automatic logic non_intrusive(input debug_cmd_type c);
      case (c)
         CMD_MEM_ACCESS, CMD_MEM_STATUS, CMD_DBGREG_ACCESS, CMD_BACKGROUND: begin
            non_intrusive = 1'b1;
         end
         default: begin
            non_intrusive = 1'b0;
         end
      endcase
   endfunction

   // Commands that wait mode still answers; the rest need a running bus
   function automatic logic wait_allowed(input debug_cmd_type c);
      case (c)
         CMD_MEM_STATUS, CMD_BACKGROUND: begin
            wait_allowed = 1'b1;
         end
         default: begin
            wait_allowed = 1'b0;
         end
      endcase
   endfunction

   // Command acceptance per mode; one answer per request, next cycle
   always_comb begin
      resp_next = '0;
      resp_next.valid = debug_req_i.valid;
      resp_next.status = STATUS_OK;
      if (debug_req_i.valid) begin
         case (mode_reg)
            MODE_RUN: begin
               if (non_intrusive(debug_req_i.cmd)) begin
                  resp_next.execute = 1'b1;
               end else begin
                  resp_next.status = STATUS_REFUSED;
               end
            end
            MODE_HALT_TO_DEBUG_INSTRUCTION: begin
               resp_next.execute = 1'b1;
            end
            MODE_WAIT: begin
               if (!wait_allowed(debug_req_i.cmd)) begin
                  resp_next.status = STATUS_REFUSED;
               end else if (debug_req_i.cmd == CMD_MEM_STATUS) begin
                  // No memory cycle is started while the bus sleeps
                  resp_next.status = STATUS_LOW_POWER;
               end else begin
                  resp_next.execute = 1'b1;
               end
            end
            default: begin
               // Reset, vector fetch and trace step take no commands
               resp_next.status = STATUS_REFUSED;
            end
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         debug_resp_o <= '0;
      end else begin
         debug_resp_o <= resp_next;
      end
   end

   mode_clock_gate u_clock_gate (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .cpu_run_i(cpu_run_next),
      .gate_regs_i(peripheral_clock_gate_regs_i),
      .cpu_clk_en_o(cpu_clk_en_o),
      .periph_clk_en_o(periph_clk_en_o),
      .sys_clk_en_o(sys_clk_en_o),
      .regulator_full_o(regulator_full_o)
   );

endmodule
